// *** rtl/dwrb_defines.svh ***
// Constants of the dual wiper register bank.
// Contract
// - Write, increment, decrement at 01h move channel 0 tap; read returns it.
// - Write, increment, decrement at 02h move channel 1 tap; read returns it.
// - Position is a 10-bit code; 3FFh full scale, 000h zero scale.
// - Volatile and start-up wiper registers default to midscale 200h.
// - Bits 15 to 10 of wiper and storage registers read zero.
// - Start-up registers hold power-up positions; only read and write allowed.
// - SPI: increment or decrement of a stored register sets command error.
// - I2C: increment or decrement of a stored register is refused by NACK.
// - Three storage registers hold 10-bit user data, default zero.
// - Status register is read-only; bits 15 to 7 read zero.
// - Status read clears command, check, soft reset, power-up flags after.
// - Bit 6 reports a memory error correction; it steers nothing.
// - SPI only: bit 5 set when serial watchdog reset the interface.
// - SPI only: bit 4 set on any command error since last read.
// - Bit 3 set on check mismatch while checking on, not daisy chained in SPI.
// - Bit 2 set when a software reset was detected.
// - Bit 1 set by power-on reset until status is first read.
// - Bit 0 is one while a stored write or start-up is running.
// - Each stored write bumps its wear counter; at 1000 writes are refused.
// - After any reset wipers load from start-up registers, not later.
`ifndef DWRB_DEFINES_SVH
`define DWRB_DEFINES_SVH

`define DWRB_ADDR_W        5
`define DWRB_DATA_W        16
`define DWRB_POS_W         10
`define DWRB_STAT_W        7
`define DWRB_CNT_W         16
`define DWRB_NV_NUM        5

`define DWRB_ADDR_WIPER0   5'h01
`define DWRB_ADDR_WIPER1   5'h02
`define DWRB_ADDR_START0   5'h03
`define DWRB_ADDR_STORE2   5'h07
`define DWRB_ADDR_STATUS   5'h08

`define DWRB_POS_MID       10'h200
`define DWRB_POS_FULL      10'h3FF
`define DWRB_POS_ZERO      10'h000
`define DWRB_STORE_RESET   10'h000
`define DWRB_WEAR_LIMIT    10'h3E8

`define DWRB_STAT_BUSY     0
`define DWRB_STAT_POWERUP  1
`define DWRB_STAT_SOFTRST  2
`define DWRB_STAT_CHECK    3
`define DWRB_STAT_COMMAND_ERROR_FLAG   4
`define DWRB_STAT_WDOG     5
`define DWRB_STAT_CORRECT  6
`define DWRB_STAT_RESET    7'h02
`define DWRB_STAT_RDCLEAR  7'h1E

`define DWRB_CLK_NS        20
`define DWRB_NVWRITE_NS    10000
`define DWRB_STARTUP_NS    2000
`define DWRB_NVWRITE_CYC   ((`DWRB_NVWRITE_NS + `DWRB_CLK_NS - 1) / `DWRB_CLK_NS)
`define DWRB_STARTUP_CYC   ((`DWRB_STARTUP_NS + `DWRB_CLK_NS - 1) / `DWRB_CLK_NS)

`endif

// *** rtl/dwrb_pkg.sv ***
// Types shared by the dual wiper register bank.
`default_nettype none
`include "dwrb_defines.svh"
package dwrb_pkg;
	typedef enum logic [1:0]
	{
		DWRB_CMD_WRITE,
		DWRB_CMD_INC,
		DWRB_CMD_DEC,
		DWRB_CMD_READ
	} dwrb_cmd_e;

	typedef struct packed
	{
		dwrb_cmd_e                cmd;
		logic [`DWRB_ADDR_W-1:0]  addr;
		logic [`DWRB_DATA_W-1:0]  data;
	} dwrb_req_s;

	typedef struct packed
	{
		logic [`DWRB_DATA_W-1:0]  data;
		logic                     nack;
	} dwrb_rsp_s;
endpackage
`default_nettype wire

// *** rtl/dwrb_top.sv ***
// Register bank of the dual wiper device with a link-clock command port.
`timescale 1ns/1ps
`default_nettype none
`include "dwrb_defines.svh"
module dwrb_top
(
	// Core clock and reset
	input  wire logic                        mclk,
	input  wire logic                        resetn,
	// Static pins and sideband from neighbouring logic
	input  wire logic                        spiModePin,
	input  wire logic                        checkEnable,
	input  wire logic                        daisyChain,
	input  wire logic                        softResetReq,
	input  wire logic                        nvCorrected,
	// Link side, clocked by linkClk
	input  wire logic                        linkClk,
	input  wire logic                        linkReqValid,
	input  wire dwrb_pkg::dwrb_req_s         linkReq,
	input  wire logic                        linkWdogEvt,
	input  wire logic                        linkCheckEvt,
	output logic                             linkBusy,
	output logic                             linkRspValid,
	output dwrb_pkg::dwrb_rsp_s              linkRsp,
	// Ladder taps and activity
	output logic [`DWRB_POS_W-1:0]           tapCh0,
	output logic [`DWRB_POS_W-1:0]           tapCh1,
	output logic                             nvActive
);
	import dwrb_pkg::*;

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic logic dwrb_is_nv(input logic [`DWRB_ADDR_W-1:0] a);
		return (a >= `DWRB_ADDR_START0) && (a <= `DWRB_ADDR_STORE2);
	endfunction

	function automatic logic [2:0] dwrb_nv_index(
		input logic [`DWRB_ADDR_W-1:0] a);
		logic [`DWRB_ADDR_W-1:0] d;
		d = a - `DWRB_ADDR_START0;
		return d[2:0];
	endfunction

	// Saturating step keeps the tap pinned at either end of the ladder.
	function automatic logic [`DWRB_POS_W-1:0] dwrb_step(
		input logic [`DWRB_POS_W-1:0]  pos,
		input dwrb_cmd_e               cmd,
		input logic [`DWRB_DATA_W-1:0] wdata);
		logic [`DWRB_POS_W-1:0] r;
		r = pos;
		unique case (cmd)
			DWRB_CMD_WRITE: r = wdata[`DWRB_POS_W-1:0];
			DWRB_CMD_INC:   r = (pos == `DWRB_POS_FULL) ? pos : pos + 1'b1;
			DWRB_CMD_DEC:   r = (pos == `DWRB_POS_ZERO) ? pos : pos - 1'b1;
			DWRB_CMD_READ:  r = pos;
		endcase
		return r;
	endfunction

	// ------------------------------------------------------------
	// Reset release in both domains
	// ------------------------------------------------------------
	logic [1:0]                     rstPipe_reg;
	logic [1:0]                     linkRstPipe_reg;
	logic                           rstN;
	logic                           linkRstN;

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			rstPipe_reg <= 2'h0;
		else
			rstPipe_reg <= {rstPipe_reg[0], 1'b1};
	end

	always_ff @(posedge linkClk or negedge resetn)
	begin
		if (!resetn)
			linkRstPipe_reg <= 2'h0;
		else
			linkRstPipe_reg <= {linkRstPipe_reg[0], 1'b1};
	end

	assign rstN     = rstPipe_reg[1];
	assign linkRstN = linkRstPipe_reg[1];

	// ------------------------------------------------------------
	// Link domain: request hold, toggles out, answer back
	// ------------------------------------------------------------
	dwrb_req_s                      reqHold_reg;
	logic                           reqTgl_reg;
	logic                           pending_reg;
	logic [2:0]                     ackSync_reg;
	logic                           ackEdge;
	logic                           rspValid_reg;
	dwrb_rsp_s                      rspOut_reg;
	logic [1:0]                     evtTgl_reg;
	logic [1:0]                     linkEvt;

	assign ackEdge = ackSync_reg[2] ^ ackSync_reg[1];
	assign linkEvt = {linkCheckEvt, linkWdogEvt};

	// A new request is ignored while the previous one is still in flight.
	always_ff @(posedge linkClk or negedge linkRstN)
	begin
		if (!linkRstN)
		begin
			reqHold_reg <= '0;
			reqTgl_reg  <= 1'b0;
			pending_reg <= 1'b0;
		end
		else if (linkReqValid && !pending_reg)
		begin
			reqHold_reg <= linkReq;
			reqTgl_reg  <= ~reqTgl_reg;
			pending_reg <= 1'b1;
		end
		else if (ackEdge)
			pending_reg <= 1'b0;
	end

	logic                           ackTgl_reg;
	dwrb_rsp_s                      rspHold_reg;

	always_ff @(posedge linkClk or negedge linkRstN)
	begin
		if (!linkRstN)
		begin
			ackSync_reg  <= 3'h0;
			rspValid_reg <= 1'b0;
			rspOut_reg   <= '0;
		end
		else
		begin
			ackSync_reg  <= {ackSync_reg[1:0], ackTgl_reg};
			rspValid_reg <= ackEdge;
			if (ackEdge)
				rspOut_reg <= rspHold_reg;
		end
	end

	// ------------------------------------------------------------
	// Link events cross as toggles
	// ------------------------------------------------------------
	logic [2:0]                     evtSync_reg [2];
	logic [1:0]                     evtEdge;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_evt
			always_ff @(posedge linkClk or negedge linkRstN)
			begin
				if (!linkRstN)
					evtTgl_reg[g] <= 1'b0;
				else if (linkEvt[g])
					evtTgl_reg[g] <= ~evtTgl_reg[g];
			end

			always_ff @(posedge mclk or negedge rstN)
			begin
				if (!rstN)
					evtSync_reg[g] <= 3'h0;
				else
					evtSync_reg[g] <= {evtSync_reg[g][1:0], evtTgl_reg[g]};
			end

			assign evtEdge[g] = evtSync_reg[g][2] ^ evtSync_reg[g][1];
		end
	endgenerate

	// ------------------------------------------------------------
	// Core domain: request arrival and mode pin
	// ------------------------------------------------------------
	logic [2:0]                     reqSync_reg;
	logic [1:0]                     modeSync_reg;
	logic                           cmdNow;
	logic                           spiMode;

	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
		begin
			reqSync_reg  <= 3'h0;
			modeSync_reg <= 2'h0;
		end
		else
		begin
			reqSync_reg  <= {reqSync_reg[1:0], reqTgl_reg};
			modeSync_reg <= {modeSync_reg[0], spiModePin};
		end
	end

	// The held request changes with its toggle, at least two mclk edges before cmdNow rises.
	assign cmdNow  = reqSync_reg[2] ^ reqSync_reg[1];
	assign spiMode = modeSync_reg[1];

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [`DWRB_POS_W-1:0]         wiper_reg [2];
	logic [`DWRB_POS_W-1:0]         nvMem_reg [`DWRB_NV_NUM];
	logic [`DWRB_POS_W-1:0]         wear_reg  [`DWRB_NV_NUM];
	logic [`DWRB_STAT_W-1:1]        flags_reg;
	logic                           nvBusy_reg;
	logic                           startup_reg;
	logic [`DWRB_CNT_W-1:0]         busyCnt_reg;

	// ------------------------------------------------------------
	// Command decode and read mux
	// ------------------------------------------------------------
	logic                           isVol;
	logic                           isNv;
	logic                           isStat;
	logic [2:0]                     nvIdx;
	logic                           refuse;
	logic                           accept;
	logic                           nvWrite;
	logic                           statRead;
	logic [`DWRB_DATA_W-1:0]        rdData;
	logic [`DWRB_STAT_W-1:0]        statusWord;

	assign statusWord = {flags_reg, nvBusy_reg};

	always_comb
	begin
		isVol  = (reqHold_reg.addr == `DWRB_ADDR_WIPER0) ||
		         (reqHold_reg.addr == `DWRB_ADDR_WIPER1);
		isNv   = dwrb_is_nv(reqHold_reg.addr);
		isStat = (reqHold_reg.addr == `DWRB_ADDR_STATUS);
		nvIdx  = dwrb_nv_index(reqHold_reg.addr);
		rdData = 16'h0000;
		if (reqHold_reg.addr == `DWRB_ADDR_WIPER0)
			rdData[`DWRB_POS_W-1:0] = wiper_reg[0];
		else if (reqHold_reg.addr == `DWRB_ADDR_WIPER1)
			rdData[`DWRB_POS_W-1:0] = wiper_reg[1];
		else if (isNv)
			rdData[`DWRB_POS_W-1:0] = nvMem_reg[nvIdx];
		else if (isStat)
			rdData[`DWRB_STAT_W-1:0] = statusWord;
		refuse = 1'b1;
		unique case (reqHold_reg.cmd)
			DWRB_CMD_READ:  refuse = !(isVol || isNv || isStat);
			DWRB_CMD_WRITE: refuse = !(isVol || isNv) || nvBusy_reg ||
			                (isNv && (wear_reg[nvIdx] >= `DWRB_WEAR_LIMIT));
			DWRB_CMD_INC,
			DWRB_CMD_DEC:   refuse = !isVol || nvBusy_reg;
		endcase
		accept   = cmdNow && !refuse;
		nvWrite  = accept && isNv && (reqHold_reg.cmd == DWRB_CMD_WRITE);
		statRead = accept && isStat && (reqHold_reg.cmd == DWRB_CMD_READ);
	end

	// ------------------------------------------------------------
	// Answer back to the link
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
		begin
			ackTgl_reg  <= 1'b0;
			rspHold_reg <= '0;
		end
		else if (cmdNow)
		begin
			ackTgl_reg       <= ~ackTgl_reg;
			rspHold_reg.data <= rdData;
			rspHold_reg.nack <= refuse && !spiMode;
		end
	end

	// ------------------------------------------------------------
	// Start-up and stored-write timer
	// ------------------------------------------------------------
	logic                           startupDone;

	assign startupDone = nvBusy_reg && startup_reg && !softResetReq &&
	                     (busyCnt_reg == '0);

	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
		begin
			nvBusy_reg  <= 1'b1;
			startup_reg <= 1'b1;
			busyCnt_reg <= `DWRB_CNT_W'(`DWRB_STARTUP_CYC - 1);
		end
		else if (softResetReq)
		begin
			nvBusy_reg  <= 1'b1;
			startup_reg <= 1'b1;
			busyCnt_reg <= `DWRB_CNT_W'(`DWRB_STARTUP_CYC - 1);
		end
		else if (nvWrite)
		begin
			nvBusy_reg  <= 1'b1;
			busyCnt_reg <= `DWRB_CNT_W'(`DWRB_NVWRITE_CYC - 1);
		end
		else if (nvBusy_reg)
		begin
			if (busyCnt_reg == '0)
			begin
				nvBusy_reg  <= 1'b0;
				startup_reg <= 1'b0;
			end
			else
				busyCnt_reg <= busyCnt_reg - 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Volatile wipers
	// ------------------------------------------------------------
	generate
		for (g = 0; g < 2; g++)
		begin : g_wiper
			always_ff @(posedge mclk or negedge rstN)
			begin
				if (!rstN)
					wiper_reg[g] <= `DWRB_POS_MID;
				else if (startupDone)
					wiper_reg[g] <= nvMem_reg[g];
				else if (accept && isVol &&
				         (reqHold_reg.addr[1:0] == 2'(g + 1)))
					wiper_reg[g] <= dwrb_step(wiper_reg[g],
					                          reqHold_reg.cmd,
					                          reqHold_reg.data);
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Stored registers and wear counters
	// ------------------------------------------------------------
	generate
		for (g = 0; g < `DWRB_NV_NUM; g++)
		begin : g_nv
			always_ff @(posedge mclk or negedge rstN)
			begin
				if (!rstN)
				begin
					nvMem_reg[g] <= (g < 2) ? `DWRB_POS_MID
					                        : `DWRB_STORE_RESET;
					wear_reg[g]  <= 10'h000;
				end
				else if (nvWrite && (nvIdx == 3'(g)))
				begin
					nvMem_reg[g] <= reqHold_reg.data[`DWRB_POS_W-1:0];
					wear_reg[g]  <= wear_reg[g] + 1'b1;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Status flags: a new event wins over the clear of a read
	// ------------------------------------------------------------
	logic [`DWRB_STAT_W-1:0]        flagSet;
	logic [`DWRB_STAT_W-1:0]        flagClr;

	always_comb
	begin
		flagSet = '0;
		flagSet[`DWRB_STAT_CORRECT] = nvCorrected;
		flagSet[`DWRB_STAT_WDOG]    = evtEdge[0] && spiMode;
		flagSet[`DWRB_STAT_COMMAND_ERROR_FLAG]  = cmdNow && refuse && spiMode;
		flagSet[`DWRB_STAT_CHECK]   = evtEdge[1] && checkEnable &&
		                              !(spiMode && daisyChain);
		flagSet[`DWRB_STAT_SOFTRST] = softResetReq;
		flagClr = statRead ? `DWRB_STAT_RDCLEAR : '0;
	end

	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			flags_reg <= 6'(`DWRB_STAT_RESET >> 1);
		else
			flags_reg <= flagSet[`DWRB_STAT_W-1:1] |
			             (flags_reg & ~flagClr[`DWRB_STAT_W-1:1]);
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign linkBusy     = pending_reg;
	assign linkRspValid = rspValid_reg;
	assign linkRsp      = rspOut_reg;
	assign tapCh0       = wiper_reg[0];
	assign tapCh1       = wiper_reg[1];
	assign nvActive     = nvBusy_reg;

endmodule // dwrb_top
`default_nettype wire

// *** rtl/HANDOVER_placeholder_none.sv ***
// Intentionally empty companion file.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** tb/dwrb_host_model.sv ***
// Host controller model on the link request port.
`timescale 1ns/1ps
`default_nettype none
module dwrb_host_model
(
	// Link clock and answer
	input wire logic                linkClk,
	input wire logic                linkBusy,
	input wire logic                linkRspValid,
	input wire dwrb_pkg::dwrb_rsp_s linkRsp,
	// Request
	output logic                    linkReqValid,
	output dwrb_pkg::dwrb_req_s     linkReq
);
	import dwrb_pkg::*;
	int lost = 0;
	initial
	begin
		linkReqValid = 1'b0;
		linkReq = '0;
	end
	task automatic raw(input dwrb_cmd_e cmd, input logic [4:0] a,
		input logic [15:0] d, output dwrb_rsp_s rsp);
		int n;
		@(posedge linkClk);
		#1;
		linkReqValid = 1'b1;
		linkReq = '{cmd, a, d};
		n = 0;
		do
		begin
			@(posedge linkClk);
			n++;
		end
		while (linkBusy !== 1'b0 && n < 50);
		#1;
		linkReqValid = 1'b0;
		// Released lines show a changed word, never the last one.
		linkReq = ~linkReq;
		n = 0;
		while (linkRspValid !== 1'b1 && n < 50)
		begin
			@(posedge linkClk);
			n++;
		end
		if (n >= 50)
			lost++;
		rsp = linkRsp;
	endtask
	task automatic xfer(input dwrb_cmd_e cmd, input logic [4:0] a,
		input logic [15:0] d, output dwrb_rsp_s rsp);
		dwrb_rsp_s st;
		int n;
		n = 0;
		st = '0;
		st.data[0] = 1'b1;
		// Only the busy bit is looked at.
		while (cmd != DWRB_CMD_READ && st.data[0] !== 1'b0 && n < 100)
		begin
			raw(DWRB_CMD_READ, 5'h08, 16'h0000, st);
			n++;
		end
		// A busy flag that never clears is counted as a lost answer.
		if (cmd != DWRB_CMD_READ && st.data[0] !== 1'b0)
			lost++;
		raw(cmd, a, d, rsp);
	endtask
endmodule // dwrb_host_model
`default_nettype wire

// *** tb/dwrb_top_properties.sv ***
// Port-level checks of the dual wiper register bank.
`timescale 1ns/1ps
`default_nettype none
module dwrb_top_properties
(
	// Clocks and reset
	input wire logic                mclk,
	input wire logic                resetn,
	input wire logic                linkClk,
	// Watched signals
	input wire logic                softResetReq,
	input wire logic                linkReqValid,
	input wire logic                linkBusy,
	input wire logic                linkRspValid,
	input wire dwrb_pkg::dwrb_rsp_s linkRsp,
	input wire logic [9:0]          tapCh0,
	input wire logic [9:0]          tapCh1,
	input wire logic                nvActive
);
	import dwrb_pkg::*;
	logic [15:0] actCnt_reg;
	// Length of the current busy stretch, so long waits need no repetition.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			actCnt_reg <= 16'h0000;
		else if (nvActive)
			actCnt_reg <= actCnt_reg + 16'h0001;
		else
			actCnt_reg <= 16'h0000;
	end
	sequence s_accept;
		linkReqValid && !linkBusy;
	endsequence
	sequence s_answer;
		linkBusy[*2] ##[1:8] linkRspValid;
	endsequence
	accept_flow_a: assert property (@(posedge linkClk)
		disable iff (!resetn) s_accept |=> s_answer)
		else $error("request not answered in time");
	rsp_pulse_a: assert property (@(posedge linkClk)
		disable iff (!resetn) linkRspValid |=> !linkRspValid)
		else $error("answer strobe longer than one cycle");
	busy_drop_a: assert property (@(posedge linkClk)
		disable iff (!resetn) $fell(linkBusy) |-> linkRspValid)
		else $error("busy fell without an answer");
	rsp_hold_a: assert property (@(posedge linkClk)
		disable iff (!resetn) $changed(linkRsp) |-> linkRspValid)
		else $error("answer word changed between answers");
	upper_zero_a: assert property (@(posedge linkClk)
		disable iff (!resetn)
		linkRspValid |-> linkRsp.data[15:10] == 6'h00)
		else $error("unimplemented bits read as one");
	reset_mid_a: assert property (@(posedge mclk)
		disable iff (!resetn)
		$rose(resetn) |-> tapCh0 == 10'h200 && tapCh1 == 10'h200)
		else $error("taps not at midscale after reset");
	startup_busy_a: assert property (@(posedge mclk)
		disable iff (!resetn) $rose(resetn) |-> nvActive[*8])
		else $error("start-up not flagged as busy");
	soft_busy_a: assert property (@(posedge mclk)
		disable iff (!resetn) softResetReq |-> ##[1:2] nvActive)
		else $error("soft reset did not start up again");
	active_min_a: assert property (@(posedge mclk)
		disable iff (!resetn) $fell(nvActive) |-> actCnt_reg >= 16'h0064)
		else $error("busy flag dropped too early");
	active_max_a: assert property (@(posedge mclk)
		disable iff (!resetn) actCnt_reg < 16'h0258)
		else $error("busy flag stuck high");
endmodule // dwrb_top_properties
bind dwrb_top dwrb_top_properties u_props
(
	.mclk(mclk),
	.resetn(resetn),
	.linkClk(linkClk),
	.softResetReq(softResetReq),
	.linkReqValid(linkReqValid),
	.linkBusy(linkBusy),
	.linkRspValid(linkRspValid),
	.linkRsp(linkRsp),
	.tapCh0(tapCh0),
	.tapCh1(tapCh1),
	.nvActive(nvActive)
);
`default_nettype wire

// *** tb/dwrb_top_tb.sv ***
// Self-checking bench of the dual wiper register bank.
`timescale 1ns/1ps
`default_nettype none
module dwrb_top_tb;
	import dwrb_pkg::*;
	logic mclk, resetn, spiModePin, checkEnable, daisyChain;
	logic softResetReq, nvCorrected, linkClk, linkReqValid;
	logic linkWdogEvt, linkCheckEvt, linkBusy, linkRspValid, nvActive;
	logic [9:0] tapCh0, tapCh1;
	dwrb_req_s linkReq;
	dwrb_rsp_s linkRsp, r;
	int err_total = 0;
	int samples_checked = 0;
	dwrb_top u_dut (.mclk(mclk), .resetn(resetn), .spiModePin(spiModePin),
		.checkEnable(checkEnable), .daisyChain(daisyChain),
		.softResetReq(softResetReq), .nvCorrected(nvCorrected),
		.linkClk(linkClk), .linkReqValid(linkReqValid), .linkReq(linkReq),
		.linkWdogEvt(linkWdogEvt), .linkCheckEvt(linkCheckEvt),
		.linkBusy(linkBusy), .linkRspValid(linkRspValid),
		.linkRsp(linkRsp), .tapCh0(tapCh0), .tapCh1(tapCh1),
		.nvActive(nvActive));
	dwrb_host_model u_host (.linkClk(linkClk), .linkBusy(linkBusy),
		.linkRspValid(linkRspValid), .linkRsp(linkRsp),
		.linkReqValid(linkReqValid), .linkReq(linkReq));
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial
	begin
		linkClk = 1'b0;
		#7;
		forever #24 linkClk = ~linkClk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		if (err_total == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		u_host.raw(DWRB_CMD_READ, a, 16'h0000, r);
		check(r.data, exp);
	endtask
	task automatic op(input dwrb_cmd_e c, input logic [4:0] a,
		input logic [15:0] d);
		u_host.xfer(c, a, d, r);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (3) @(posedge mclk);
		while (nvActive !== 1'b0 && n < 2000)
		begin
			@(posedge mclk);
			n++;
		end
		check({15'h0000, nvActive}, 16'h0000);
	endtask
	task automatic link_pulse(input logic wd);
		@(posedge linkClk);
		#1;
		linkWdogEvt = wd;
		linkCheckEvt = !wd;
		@(posedge linkClk);
		#1;
		linkWdogEvt = 1'b0;
		linkCheckEvt = 1'b0;
		repeat (4) @(posedge linkClk);
	endtask
	task automatic t_reset();
		wait_idle();
		check({tapCh1, tapCh0[5:0]}, 16'h8000);
		rd(5'h08, 16'h0002);
		rd(5'h08, 16'h0000);
		for (int a = 1; a < 8; a++)
			rd(a[4:0], (a < 5) ? 16'h0200 : 16'h0000);
	endtask
	task automatic t_volatile();
		op(DWRB_CMD_WRITE, 5'h01, 16'hFFFE);
		check(r.data, 16'h0200);
		op(DWRB_CMD_INC, 5'h01, 16'h0000);
		op(DWRB_CMD_INC, 5'h01, 16'h0000);
		rd(5'h01, 16'h03FF);
		check({6'h00, tapCh0}, 16'h03FF);
		op(DWRB_CMD_WRITE, 5'h02, 16'h0001);
		op(DWRB_CMD_DEC, 5'h02, 16'h0000);
		op(DWRB_CMD_DEC, 5'h02, 16'h0000);
		rd(5'h02, 16'h0000);
		check({6'h00, tapCh1}, 16'h0000);
	endtask
	task automatic t_refuse();
		for (int c = 1; c < 3; c++)
			for (int a = 3; a < 9; a++)
			begin
				op(dwrb_cmd_e'(c), a[4:0], 16'h0000);
				check({15'h0000, r.nack}, 16'h0000);
				rd(5'h08, 16'h0010);
			end
		op(DWRB_CMD_WRITE, 5'h08, 16'h007F);
		rd(5'h08, 16'h0010);
		op(DWRB_CMD_WRITE, 5'h10, 16'h0001);
		rd(5'h08, 16'h0010);
		rd(5'h00, 16'h0000);
		rd(5'h08, 16'h0010);
		rd(5'h03, 16'h0200);
	endtask
	task automatic t_i2c();
		@(posedge mclk);
		#1;
		spiModePin = 1'b0;
		repeat (4) @(posedge mclk);
		for (int a = 3; a < 8; a++)
		begin
			op(DWRB_CMD_DEC, a[4:0], 16'h0000);
			check({15'h0000, r.nack}, 16'h0001);
		end
		link_pulse(1'b1);
		rd(5'h08, 16'h0000);
		@(posedge mclk);
		#1;
		spiModePin = 1'b1;
		repeat (4) @(posedge mclk);
	endtask
	task automatic t_stored();
		op(DWRB_CMD_WRITE, 5'h05, 16'hFD5A);
		rd(5'h08, 16'h0001);
		rd(5'h05, 16'h015A);
		u_host.raw(DWRB_CMD_DEC, 5'h01, 16'h0000, r);
		rd(5'h08, 16'h0011);
		op(DWRB_CMD_WRITE, 5'h03, 16'h0123);
		rd(5'h03, 16'h0123);
		check({6'h00, tapCh0}, 16'h03FF);
		wait_idle();
		@(posedge mclk);
		#1;
		softResetReq = 1'b1;
		@(posedge mclk);
		#1;
		softResetReq = 1'b0;
		wait_idle();
		check({tapCh0, tapCh1[5:0]}, 16'h48C0);
		rd(5'h08, 16'h0004);
		rd(5'h02, 16'h0200);
	endtask
	task automatic t_events();
		@(posedge mclk);
		#1;
		checkEnable = 1'b1;
		link_pulse(1'b1);
		link_pulse(1'b0);
		@(posedge mclk);
		#1;
		nvCorrected = 1'b1;
		@(posedge mclk);
		#1;
		nvCorrected = 1'b0;
		repeat (4) @(posedge mclk);
		rd(5'h08, 16'h0068);
		rd(5'h08, 16'h0060);
		@(posedge mclk);
		#1;
		daisyChain = 1'b1;
		link_pulse(1'b0);
		rd(5'h08, 16'h0060);
		@(posedge mclk);
		#1;
		daisyChain = 1'b0;
		checkEnable = 1'b0;
		link_pulse(1'b0);
		rd(5'h08, 16'h0060);
	endtask
	initial
	begin
		resetn = 1'b0;
		spiModePin = 1'b1;
		checkEnable = 1'b0;
		daisyChain = 1'b0;
		softResetReq = 1'b0;
		nvCorrected = 1'b0;
		linkWdogEvt = 1'b0;
		linkCheckEvt = 1'b0;
		repeat (6) @(posedge mclk);
		#1;
		resetn = 1'b1;
		t_reset();
		t_volatile();
		t_refuse();
		t_i2c();
		t_stored();
		t_events();
		err_total += u_host.lost;
		final_report();
	end
	initial
	begin
		#500000;
		err_total++;
		$display("[ERR] %0t watchdog expired", $time);
		final_report();
	end
endmodule // dwrb_top_tb
`default_nettype wire
